/* File: crl_loader.v */
/*
  Calibration register loader: holds the five 16-bit calibration registers,
  fills them from the nonvolatile store at power-on and every refresh tick
  while locked, or from the calibration host while unlocked.
  Assumes the temperature code comes from converter logic on clock_in and the
  override pin is asynchronous; host strobes are on clock_in.
*/
`default_nettype none
`include "crl_map.vh"

// Behaviour
// - Five 16-bit registers, from store or host.
// - Power-on locked: load setup, drift and trim words.
// - Trim DAC words come from pointer-selected entries.
// - Locked: full reload every one millisecond.
// - Unlocked or overridden: host writes, no reloads.
// - Store is 768 bytes, 12 erasable pages.
// - Offset table spans 000 through 15F.
// - Span table split: 200-2FF and 1A0-1FF.
// - Words: low byte even, high byte odd.
// - Pointer AF and above picks last entry.
// - Fixed words at 160, 164, 168, 16A.
// - 52 user bytes 16C-19F, not words.
// - Setup bit selects internal or external resistors.
// - DAC codes accept full 0000 to FFFF.
// - Pointer captured from sensor once per millisecond.
// - Each pointer selects one two-byte word.
// - Indexing saturates, never wraps.
module crl_loader #(
  parameter [31:0] REFRESH_CYCLES = `CRL_REFRESH_CYCLES
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire enable_in,
  input wire override_in,
  input wire [7:0] temp_code_in,
  input wire host_reg_wr_in,
  input wire [2:0] host_reg_sel_in,
  input wire [15:0] host_reg_data_in,
  input wire host_store_wr_in,
  input wire [9:0] host_store_addr_in,
  input wire [7:0] host_store_data_in,
  input wire host_page_erase_in,
  input wire [3:0] host_page_in,
  output reg [15:0] setup_word_out,
  output reg [15:0] offset_drift_dac_out,
  output reg [15:0] span_drift_dac_out,
  output reg [15:0] offset_trim_dac_out,
  output reg [15:0] span_trim_dac_out,
  output reg [7:0] thermal_pointer_out,
  output reg internal_resistors_out,
  output reg locked_out,
  output reg busy_out,
  output reg host_done_out
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_LK_REQ = 9'h002;
  localparam [8:0] ST_LK_WAIT = 9'h004;
  localparam [8:0] ST_LK_CHK = 9'h008;
  localparam [8:0] ST_LO_REQ = 9'h010;
  localparam [8:0] ST_LO_WAIT = 9'h020;
  localparam [8:0] ST_HI_REQ = 9'h040;
  localparam [8:0] ST_HI_WAIT = 9'h080;
  localparam [8:0] ST_COMMIT = 9'h100;

  reg [8:0] state;
  reg [8:0] next_state;
  reg override_meta;
  reg override_sync;
  reg start_pending;
  reg [9:0] rd_addr;
  reg [7:0] low_byte;
  reg [2:0] word_sel;
  reg [9:0] word_addr;
  reg [7:0] ptr_index;
  reg [7:0] lock_byte;
  wire [7:0] rd_data;
  wire tick;
  wire unlocked;
  wire store_wr;
  wire store_erase;

  crl_tick #(
    .CYCLES(REFRESH_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(enable_in),
    .tick_out(tick)
  );

  // Writes and erases are refused while the store is locked and not overridden.
  assign unlocked = (lock_byte == `CRL_LOCK_CLEAR) || override_sync;
  assign store_wr = host_store_wr_in && unlocked && !busy_out;
  assign store_erase = host_page_erase_in && unlocked && !busy_out;

  crl_store u_store (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(enable_in),
    .wr_in(store_wr),
    .wr_addr_in(host_store_addr_in),
    .wr_data_in(host_store_data_in),
    .erase_in(store_erase),
    .erase_page_in(host_page_in),
    .rd_addr_in(rd_addr),
    .rd_data_out(rd_data)
  );

  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      override_meta <= 1'b0;
      override_sync <= 1'b0;
    end
    else if (enable_in)
    begin
      override_meta <= override_in;
      override_sync <= override_meta;
    end
  end

  // Saturating index: codes above the table top reuse the last entry.
  always @*
  begin
    if (thermal_pointer_out > `CRL_PTR_MAX)
      ptr_index = `CRL_PTR_MAX;
    else
      ptr_index = thermal_pointer_out;
  end

  // Address of the low byte of the word being fetched.
  always @*
  begin
    case (word_sel)
      `CRL_SEL_SETUP:
        word_addr = `CRL_SETUP_ADDR;
      `CRL_SEL_OFFSET_DRIFT:
        word_addr = `CRL_OFFSET_DRIFT_ADDR;
      `CRL_SEL_SPAN_DRIFT:
        word_addr = `CRL_SPAN_DRIFT_ADDR;
      `CRL_SEL_OFFSET_TRIM:
        word_addr = `CRL_OFFSET_TABLE_BASE + {1'b0, ptr_index, 1'b0};
      `CRL_SEL_SPAN_TRIM:
        if (ptr_index < `CRL_SPAN_SPLIT_PTR)
          word_addr = `CRL_SPAN_LOW_BASE + {2'b00, ptr_index[6:0], 1'b0};
        else
          word_addr = `CRL_SPAN_HIGH_BASE + {2'b00, ptr_index[6:0], 1'b0};
      default:
        word_addr = `CRL_SETUP_ADDR;
    endcase
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_pending)
          next_state = ST_LK_REQ;
      ST_LK_REQ:
        next_state = ST_LK_WAIT;
      ST_LK_WAIT:
        next_state = ST_LK_CHK;
      ST_LK_CHK:
        // Only a fully set lock byte with the override low reloads.
        if (rd_data == `CRL_LOCK_SET && !override_sync)
          next_state = ST_LO_REQ;
        else
          next_state = ST_IDLE;
      ST_LO_REQ:
        next_state = ST_LO_WAIT;
      ST_LO_WAIT:
        next_state = ST_HI_REQ;
      ST_HI_REQ:
        next_state = ST_HI_WAIT;
      ST_HI_WAIT:
        next_state = ST_COMMIT;
      ST_COMMIT:
        if (word_sel == `CRL_SEL_LAST)
          next_state = ST_IDLE;
        else
          next_state = ST_LO_REQ;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      start_pending <= 1'b1;
      rd_addr <= 10'h000;
      low_byte <= 8'h00;
      word_sel <= `CRL_SEL_SETUP;
      lock_byte <= `CRL_LOCK_CLEAR;
      thermal_pointer_out <= 8'h00;
      busy_out <= 1'b0;
      locked_out <= 1'b0;
    end
    else if (enable_in)
    begin
      state <= next_state;
      if (tick)
      begin
        thermal_pointer_out <= temp_code_in;
        start_pending <= 1'b1;
      end
      else if (state == ST_IDLE && start_pending)
        start_pending <= 1'b0;
      if (state == ST_IDLE && start_pending)
      begin
        busy_out <= 1'b1;
        // The first pass after reset uses the current sensor code directly.
        if (!tick && !locked_out && lock_byte == `CRL_LOCK_CLEAR)
          thermal_pointer_out <= temp_code_in;
      end
      case (state)
        ST_LK_REQ:
          rd_addr <= `CRL_LOCK_BYTE_ADDR;
        ST_LK_CHK:
        begin
          lock_byte <= rd_data;
          locked_out <= (rd_data == `CRL_LOCK_SET) && !override_sync;
          word_sel <= `CRL_SEL_SETUP;
          if (!(rd_data == `CRL_LOCK_SET && !override_sync))
            busy_out <= 1'b0;
        end
        ST_LO_REQ:
          rd_addr <= word_addr;
        ST_HI_REQ:
        begin
          low_byte <= rd_data;
          rd_addr <= word_addr + 10'h001;
        end
        ST_COMMIT:
        begin
          word_sel <= word_sel + 3'h1;
          if (word_sel == `CRL_SEL_LAST)
            busy_out <= 1'b0;
        end
        default:
          rd_addr <= rd_addr;
      endcase
    end
  end

  // Calibration registers: full 16-bit codes, no clamping of any value.
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      setup_word_out <= 16'h0000;
      offset_drift_dac_out <= 16'h0000;
      span_drift_dac_out <= 16'h0000;
      offset_trim_dac_out <= 16'h0000;
      span_trim_dac_out <= 16'h0000;
      internal_resistors_out <= 1'b0;
      host_done_out <= 1'b0;
    end
    else if (enable_in)
    begin
      host_done_out <= 1'b0;
      if (state == ST_COMMIT)
      begin
        // Both bytes are in hand, so no half-written word is ever shown.
        case (word_sel)
          `CRL_SEL_SETUP:
          begin
            setup_word_out <= {rd_data, low_byte};
            internal_resistors_out <= (rd_data_bit(rd_data, low_byte));
          end
          `CRL_SEL_OFFSET_DRIFT:
            offset_drift_dac_out <= {rd_data, low_byte};
          `CRL_SEL_SPAN_DRIFT:
            span_drift_dac_out <= {rd_data, low_byte};
          `CRL_SEL_OFFSET_TRIM:
            offset_trim_dac_out <= {rd_data, low_byte};
          `CRL_SEL_SPAN_TRIM:
            span_trim_dac_out <= {rd_data, low_byte};
          default:
            host_done_out <= 1'b0;
        endcase
      end
      else if (host_reg_wr_in && unlocked && !busy_out
               && host_reg_sel_in <= `CRL_SEL_LAST)
      begin
        host_done_out <= 1'b1;
        case (host_reg_sel_in)
          `CRL_SEL_SETUP:
          begin
            setup_word_out <= host_reg_data_in;
            internal_resistors_out <= host_reg_data_in[`CRL_SETUP_RINT_BIT];
          end
          `CRL_SEL_OFFSET_DRIFT:
            offset_drift_dac_out <= host_reg_data_in;
          `CRL_SEL_SPAN_DRIFT:
            span_drift_dac_out <= host_reg_data_in;
          `CRL_SEL_OFFSET_TRIM:
            offset_trim_dac_out <= host_reg_data_in;
          default:
            span_trim_dac_out <= host_reg_data_in;
        endcase
      end
    end
  end

  // Picks the resistor select bit out of the assembled setup word.
  function rd_data_bit;
    input [7:0] high_byte;
    input [7:0] low_part;
    reg [15:0] word;
    begin
      word = {high_byte, low_part};
      rd_data_bit = word[`CRL_SETUP_RINT_BIT];
    end
  endfunction

endmodule

`default_nettype wire

/* File: crl_map.vh */
/*
  Constants for the calibration register loader: nonvolatile store layout,
  fixed word locations, lookup table bases, lock codes and refresh timing.
  Assumes it is included by its bare name from the loader's design files.
*/
`ifndef CRL_MAP_VH
`define CRL_MAP_VH

// Store geometry.
`define CRL_STORE_BYTES 768
`define CRL_PAGE_COUNT 4'hc
`define CRL_PAGE_BYTES 64
`define CRL_ERASED_BYTE 8'hff

// Fixed store locations, words with the low byte at the even address.
`define CRL_SETUP_ADDR 10'h160
`define CRL_OFFSET_DRIFT_ADDR 10'h164
`define CRL_SPAN_DRIFT_ADDR 10'h168
`define CRL_CONTROL_ADDR 10'h16a
`define CRL_LOCK_BYTE_ADDR 10'h16a
`define CRL_USER_FIRST_ADDR 10'h16c
`define CRL_USER_LAST_ADDR 10'h19f

// Lookup tables.
`define CRL_OFFSET_TABLE_BASE 10'h000
`define CRL_OFFSET_TABLE_LAST 10'h15f
`define CRL_SPAN_LOW_BASE 10'h200
`define CRL_SPAN_HIGH_BASE 10'h1a0
`define CRL_SPAN_SPLIT_PTR 8'h80
`define CRL_PTR_MAX 8'haf

// Lock byte codes.
`define CRL_LOCK_SET 8'hff
`define CRL_LOCK_CLEAR 8'h00

// Setup word bit choosing internal span feedback resistors.
`define CRL_SETUP_RINT_BIT 4

// Calibration register selectors.
`define CRL_SEL_SETUP 3'h0
`define CRL_SEL_OFFSET_DRIFT 3'h1
`define CRL_SEL_SPAN_DRIFT 3'h2
`define CRL_SEL_OFFSET_TRIM 3'h3
`define CRL_SEL_SPAN_TRIM 3'h4
`define CRL_SEL_LAST 3'h4

// Refresh timing.
`define CRL_CLK_PERIOD_NS 20
`define CRL_REFRESH_NS 1000000
`define CRL_REFRESH_CYCLES (`CRL_REFRESH_NS / `CRL_CLK_PERIOD_NS)

`endif

/* File: crl_tick.v */
/*
  Free running period timer that pulses once every CYCLES clocks.
  Assumes a synchronous active-low reset and a clock enable from the loader.
*/
`default_nettype none

module crl_tick #(
  parameter [31:0] CYCLES = 32'd50000
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire enable_in,
  output reg tick_out
);

  reg [31:0] count;

  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      count <= 32'h0000_0000;
      tick_out <= 1'b0;
    end
    else if (enable_in)
    begin
      if (count == CYCLES - 32'd1)
      begin
        count <= 32'h0000_0000;
        tick_out <= 1'b1;
      end
      else
      begin
        count <= count + 32'd1;
        tick_out <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: crl_store.v */
/*
  Byte-wide nonvolatile store model: 768 bytes in 12 pages of 64 bytes,
  one write port, page erase, and a read port with one clock of latency.
  Assumes the loader gates writes and erases by the lock state.
*/
`default_nettype none
`include "crl_map.vh"

module crl_store (
  input wire clock_in,
  input wire rst_n_in,
  input wire enable_in,
  input wire wr_in,
  input wire [9:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire erase_in,
  input wire [3:0] erase_page_in,
  input wire [9:0] rd_addr_in,
  output reg [7:0] rd_data_out
);

  reg [7:0] mem [0:`CRL_STORE_BYTES-1];
  integer i;

  // The array has no reset: its contents are meant to survive power cycles.
  always @(posedge clock_in)
  begin
    if (enable_in)
    begin
      if (erase_in && erase_page_in < `CRL_PAGE_COUNT)
      begin
        for (i = 0; i < `CRL_PAGE_BYTES; i = i + 1)
          mem[{erase_page_in, i[5:0]}] <= `CRL_ERASED_BYTE;
      end
      else if (wr_in && wr_addr_in < `CRL_STORE_BYTES)
        mem[wr_addr_in] <= wr_data_in;
    end
  end

  always @(posedge clock_in)
  begin
    if (!rst_n_in)
      rd_data_out <= 8'h00;
    else if (enable_in)
    begin
      if (rd_addr_in < `CRL_STORE_BYTES)
        rd_data_out <= mem[rd_addr_in];
      else
        rd_data_out <= `CRL_ERASED_BYTE;
    end
  end

endmodule

`default_nettype wire

/* File: crl_loader_assertions.sv */
/* Concurrent checks on the calibration register loader's ports.
   Assumes binding onto crl_loader and a clock_in domain with synchronous reset. */
`default_nettype none
`include "crl_map.vh"
module crl_loader_assertions (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic host_reg_wr_in,
  input wire logic [2:0] host_reg_sel_in,
  input wire logic [15:0] host_reg_data_in,
  input wire logic [15:0] setup_word_out,
  input wire logic [15:0] offset_trim_dac_out,
  input wire logic [15:0] span_trim_dac_out,
  input wire logic [7:0] thermal_pointer_out,
  input wire logic internal_resistors_out,
  input wire logic locked_out,
  input wire logic busy_out,
  input wire logic host_done_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence pass_start;
    $rose(busy_out);
  endsequence
  sequence lock_check;
    busy_out [*3] ##1 (locked_out ? busy_out : !busy_out);
  endsequence
  a_done_cause: assert property (host_done_out |-> $past(host_reg_wr_in)
    && !$past(busy_out) && $past(host_reg_sel_in) <= `CRL_SEL_LAST) else $error("stray done");
  a_setup_host: assert property (host_done_out && $past(host_reg_sel_in) == 3'h0
    |-> setup_word_out == $past(host_reg_data_in)) else $error("setup write lost");
  a_trim_host: assert property (host_done_out && $past(host_reg_sel_in) == 3'h4
    |-> span_trim_dac_out == $past(host_reg_data_in)) else $error("span trim write lost");
  a_lock_check: assert property (pass_start |-> lock_check)
    else $error("lock check timing wrong");
  a_pass_bound: assert property (pass_start |-> ##[3:28] !busy_out)
    else $error("reload too long");
  a_word_whole: assert property ($changed(offset_trim_dac_out)
    |-> $past(busy_out) || host_done_out) else $error("offset trim changed while idle");
  a_unlocked_frozen: assert property (!locked_out && !host_done_out
    |-> $stable(span_trim_dac_out)) else $error("reload while unlocked");
  a_resist_bit: assert property (pass_start
    |-> internal_resistors_out == setup_word_out[`CRL_SETUP_RINT_BIT]) else $error("resistor bit");
  a_ptr_start: assert property ($changed(thermal_pointer_out)
    |-> ##[0:3] $rose(busy_out)) else $error("pointer changed without reload");
  a_freeze_hold: assert property (!enable_in |=> $stable(busy_out)
    && $stable(setup_word_out) && $stable(thermal_pointer_out)) else $error("moved while frozen");
endmodule
bind crl_loader crl_loader_assertions crl_loader_assertions_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
  .host_reg_wr_in(host_reg_wr_in),
  .host_reg_sel_in(host_reg_sel_in), .host_reg_data_in(host_reg_data_in),
  .setup_word_out(setup_word_out), .offset_trim_dac_out(offset_trim_dac_out),
  .span_trim_dac_out(span_trim_dac_out), .thermal_pointer_out(thermal_pointer_out),
  .internal_resistors_out(internal_resistors_out), .locked_out(locked_out),
  .busy_out(busy_out), .host_done_out(host_done_out));
`default_nettype wire

/* File: crl_host_model.sv */
/* Calibration host model: register writes, store byte writes and page erases.
   Assumes busy_in is the loader's busy flag; acts only just after a reload pass. */
`default_nettype none
module crl_host_model (
  input wire logic clock_in,
  input wire logic busy_in,
  output logic reg_wr_out = 0,
  output logic [2:0] sel_out = 0,
  output logic [15:0] data_out = 0,
  output logic store_wr_out = 0,
  output logic [9:0] addr_out = 0,
  output logic [7:0] byte_out = 0,
  output logic erase_out = 0,
  output logic [3:0] page_out = 0
);
  // Kind 0 writes a register, 1 a store byte, 2 erases a page.
  task automatic op(input logic [1:0] kind, input logic [9:0] a, input logic [15:0] d);
    wait (busy_in);
    wait (!busy_in);
    @(posedge clock_in);
    reg_wr_out <= kind == 2'h0;
    store_wr_out <= kind == 2'h1;
    erase_out <= kind == 2'h2;
    sel_out <= a[2:0];
    addr_out <= a;
    page_out <= a[3:0];
    data_out <= d;
    byte_out <= d[7:0];
    @(posedge clock_in);
    {reg_wr_out, store_wr_out, erase_out} <= 3'h0;
    // Released data, byte and address lines show garbage so stale values cannot pass for held ones.
    data_out <= ~d;
    byte_out <= ~d[7:0];
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: crl_loader_tb_top.sv */
/* Self-checking bench for the calibration register loader.
   Assumes a shortened refresh period of 64 clocks. */
`default_nettype none
`include "crl_map.vh"
module crl_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0;
  logic rst_n_in = 0;
  logic override_in = 1;
  logic enable_in = 1;
  logic [88:0] outs;
  logic [7:0] temp_code_in = 8'h00;
  logic busy_out, host_done_out, locked_out, internal_resistors_out, busy_q;
  logic reg_wr, store_wr, erase;
  logic [2:0] sel;
  logic [15:0] data, setup_w, odrift, sdrift, otrim, strim;
  logic [9:0] addr;
  logic [7:0] byte_v, ptr, cur_ptr;
  logic [3:0] page;
  logic [7:0] mem [0:767];
  logic [15:0] regs [0:4];
  logic [88:0] notes [$];
  logic [15:0] lfsr = 16'h0061;
  logic [7:0] ptrs [6] = '{8'h00, 8'h7f, 8'h80, 8'hae, 8'haf, 8'hff};
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  crl_loader #(.REFRESH_CYCLES(32'd64)) crl_loader_i (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .enable_in(enable_in), .override_in(override_in),
    .temp_code_in(temp_code_in), .host_reg_wr_in(reg_wr), .host_reg_sel_in(sel),
    .host_reg_data_in(data), .host_store_wr_in(store_wr), .host_store_addr_in(addr),
    .host_store_data_in(byte_v), .host_page_erase_in(erase), .host_page_in(page),
    .setup_word_out(setup_w), .offset_drift_dac_out(odrift), .span_drift_dac_out(sdrift),
    .offset_trim_dac_out(otrim), .span_trim_dac_out(strim), .thermal_pointer_out(ptr),
    .internal_resistors_out(internal_resistors_out), .locked_out(locked_out),
    .busy_out(busy_out), .host_done_out(host_done_out));
  crl_host_model crl_host_model_i (.clock_in(clock_in), .busy_in(busy_out),
    .reg_wr_out(reg_wr), .sel_out(sel), .data_out(data), .store_wr_out(store_wr),
    .addr_out(addr), .byte_out(byte_v), .erase_out(erase), .page_out(page));
  assign outs = {setup_w, odrift, sdrift, otrim, strim, internal_resistors_out, ptr};
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [15:0] word(input logic [9:0] a);
    return {mem[a + 10'h001], mem[a]};
  endfunction
  function automatic logic [88:0] snap();
    return {regs[0], regs[1], regs[2], regs[3], regs[4], regs[0][`CRL_SETUP_RINT_BIT], cur_ptr};
  endfunction
  function automatic logic [9:0] off_at(input logic [7:0] p);
    logic [9:0] i;
    i = {2'h0, (p > `CRL_PTR_MAX) ? `CRL_PTR_MAX : p};
    return `CRL_OFFSET_TABLE_BASE + {i[8:0], 1'b0};
  endfunction
  function automatic logic [9:0] span_at(input logic [7:0] p);
    logic [9:0] i;
    i = {2'h0, (p > `CRL_PTR_MAX) ? `CRL_PTR_MAX : p};
    if (i < 10'h080)
      return `CRL_SPAN_LOW_BASE + {i[8:0], 1'b0};
    return `CRL_SPAN_HIGH_BASE + {i[8:0] - 9'h080, 1'b0};
  endfunction
  task automatic load(input logic [7:0] p);
    cur_ptr = p;
    regs[0] = word(`CRL_SETUP_ADDR);
    regs[1] = word(`CRL_OFFSET_DRIFT_ADDR);
    regs[2] = word(`CRL_SPAN_DRIFT_ADDR);
    regs[3] = word(off_at(p));
    regs[4] = word(span_at(p));
  endtask
  task automatic put_word(input logic [9:0] a);
    logic [15:0] w;
    w = rnd();
    mem[a] = w[7:0];
    mem[a + 10'h001] = w[15:8];
    crl_host_model_i.op(2'h1, a, {8'h00, w[7:0]});
    crl_host_model_i.op(2'h1, a + 10'h001, {8'h00, w[15:8]});
  endtask
  task automatic check(input logic [88:0] seen, input logic [88:0] want);
    tests_run++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #10 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // A result is a host write acknowledge or the end of a locked reload.
  always @(negedge clock_in)
  begin
    if (host_done_out === 1'b1 || (busy_q === 1'b1 && busy_out === 1'b0 && locked_out === 1'b1))
      if (notes.size() > 0)
        check(outs, notes.pop_front());
      else
      begin
        n_errors++;
        $display("unexpected at %0t: result with no note", $time);
      end
    busy_q = busy_out;
  end
  initial
  begin
    logic [15:0] d;
    foreach (regs[k]) regs[k] = 16'h0000;
    cur_ptr = 8'h00;
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1;
    for (int s = 0; s < 6; s++)
    begin
      d = (s == 3) ? 16'h0000 : (s == 4) ? 16'hffff : rnd();
      if (s < 5)
      begin
        regs[s] = d;
        notes.push_back(snap());
      end
      crl_host_model_i.op(2'h0, 10'(s), d);
    end
    // Erasing page 5 also leaves the lock byte at ff.
    for (int a = 320; a < 384; a++) mem[a] = `CRL_ERASED_BYTE;
    crl_host_model_i.op(2'h2, 10'h005, 16'h0000);
    put_word(`CRL_SETUP_ADDR);
    put_word(`CRL_OFFSET_DRIFT_ADDR);
    put_word(`CRL_SPAN_DRIFT_ADDR);
    foreach (ptrs[k])
    begin
      put_word(off_at(ptrs[k]));
      put_word(span_at(ptrs[k]));
    end
    foreach (ptrs[k])
    begin
      @(posedge clock_in);
      temp_code_in <= ptrs[k];
      override_in <= 0;
      // A short freeze while idle; nothing may move until it ends.
      enable_in <= 0;
      repeat (3) @(posedge clock_in);
      enable_in <= 1;
      load(ptrs[k]);
      notes.push_back(snap());
      wait (busy_out);
      wait (!busy_out);
    end
    // The locked pass that this call waits for reloads the same words.
    notes.push_back(snap());
    crl_host_model_i.op(2'h0, 10'h000, 16'h1234);
    @(posedge clock_in);
    override_in <= 1;
    regs[1] = 16'h5a5a;
    notes.push_back(snap());
    crl_host_model_i.op(2'h0, 10'h001, 16'h5a5a);
    repeat (4) @(posedge clock_in);
    check(89'(notes.size()), 89'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
